// file: verilog/svr_pkg.sv
// package: constants and types for the supervisor watchdog reset block
package svr_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    // reset hold time in ms: least, typical, most
    localparam int unsigned RESET_HOLD_MIN_MS = 140;
    localparam int unsigned RESET_HOLD_TYP_MS = 200;
    localparam int unsigned RESET_HOLD_MAX_MS = 280;
    // watchdog period in ms (1.6 s)
    localparam int unsigned WATCHDOG_PERIOD_MS = 1600;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_TYP_MS * CYC_PER_MS;
    localparam int unsigned WATCHDOG_CYC = WATCHDOG_PERIOD_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 32;
    // decoded level of the three-state kick input
    typedef enum logic [1:0]
    {
        KICK_LOW,
        KICK_HIGH,
        KICK_FLOAT
    } svr_kick_e;
    typedef enum logic
    {
        RST_IDLE,
        RST_HOLD
    } svr_rst_state_e;
endpackage : svr_pkg

// file: verilog/svr_supervisor.sv
// module: supervisor reset, watchdog, power-fail flag and supply select
`timescale 1ns/1ps
//
// Notes on behaviour
// R1: reset held nominally 200 ms after trigger
// R2: hold interval between 140 and 280 ms
// R3: supply low keeps reset asserted throughout
// R4: steady kick for 1.6 s triggers reset
// R5: host toggles kick at least every 1.6 s
// R6: kick input decoded high, low or floating
// R7: floating kick input disables the watchdog
// R8: watchdog timer cleared while reset asserted
// R9: power-fail flag low when sense below reference
// R10: output from main unless main below both
// R11: active-high reset is inverse of active-low
// R12: supply low during hold restarts full interval
// R13: watchdog restarts from zero after reset release
// R14: backup mode forces power-fail flag low
// R15: counters run from clock, cleared asynchronously by rst
module svr_supervisor
#(
    parameter int unsigned HOLD_CYC = svr_pkg::RESET_HOLD_CYC,
    parameter int unsigned WD_CYC = svr_pkg::WATCHDOG_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // comparator results
    input wire logic main_supply_low,
    input wire logic main_above_backup,
    input wire logic power_fail_sense_low,
    // three-level kick input, pre-decoded by the input stage
    input wire logic kick_is_high,
    input wire logic kick_is_low,
    // outputs to host and supply switch
    output logic reset_out_n,
    output logic reset_out,
    output logic power_fail_flag_n,
    output logic supply_from_backup
);
    import svr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    svr_kick_e kick;
    svr_rst_state_e st_r, st_nxt;
    logic [CNT_W-1:0] hold_r, hold_nxt;
    logic [CNT_W-1:0] wd_r, wd_nxt;
    logic kick_prev_r, kick_prev_nxt;
    logic rst_n_r, rst_n_nxt;
    logic rst_hi_r, rst_hi_nxt;
    logic pf_n_r, pf_n_nxt;
    logic bk_r, bk_nxt;
    logic wd_fire;
    logic kick_edge;
    logic backup_mode;

    // both-level reading counts as floating: safer to never fire
    always_comb
    begin
        if (kick_is_high && !kick_is_low)
            kick = KICK_HIGH; // [R6]
        else if (kick_is_low && !kick_is_high)
            kick = KICK_LOW; // [R6]
        else
            kick = KICK_FLOAT; // [R6]
    end

    assign backup_mode = main_supply_low && !main_above_backup; // [R10]

    ////////////////////////////////////////////////////////////////////
    // watchdog timer
    // any level change counts as service; a kick
    // narrower than one clock is not seen
    assign kick_edge = (kick == KICK_HIGH) != kick_prev_r;
    assign wd_fire = (kick != KICK_FLOAT) && !kick_edge
        && (wd_r >= CNT_W'(WD_CYC - 1)); // [R4]

    always_comb
    begin
        kick_prev_nxt = (kick == KICK_HIGH);
        if (st_r == RST_HOLD || main_supply_low)
            wd_nxt = '0; // [R8] [R13]
        else if (kick == KICK_FLOAT)
            wd_nxt = '0; // [R7]
        else if (kick_edge || wd_fire)
            wd_nxt = '0; // [R4]
        else
            wd_nxt = wd_r + CNT_W'(1); // [R15]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wd_r <= '0;
            kick_prev_r <= 1'b0;
        end
        else
        begin
            wd_r <= wd_nxt;
            kick_prev_r <= kick_prev_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset hold sequencer
    always_comb
    begin
        st_nxt = st_r;
        hold_nxt = hold_r;
        case (st_r)
            RST_IDLE:
            begin
                if (main_supply_low || wd_fire)
                begin
                    st_nxt = RST_HOLD;
                    hold_nxt = '0;
                end
            end
            RST_HOLD:
            begin
                if (main_supply_low)
                    hold_nxt = '0; // [R3] [R12]
                else if (hold_r >= CNT_W'(HOLD_CYC - 1))
                    st_nxt = RST_IDLE; // [R1] [R2]
                else
                    hold_nxt = hold_r + CNT_W'(1); // [R15]
            end
            default:
            begin
                st_nxt = RST_HOLD;
                hold_nxt = '0;
            end
        endcase
        rst_n_nxt = (st_nxt == RST_IDLE);
        rst_hi_nxt = !rst_n_nxt; // [R11]
        bk_nxt = backup_mode; // [R10]
        pf_n_nxt = !backup_mode && !power_fail_sense_low; // [R9] [R14]
    end

    // power-up enters the hold state so reset is low from the start
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= RST_HOLD;
            hold_r <= '0;
            rst_n_r <= 1'b0;
            rst_hi_r <= 1'b1;
            pf_n_r <= 1'b0;
            bk_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            hold_r <= hold_nxt;
            rst_n_r <= rst_n_nxt;
            rst_hi_r <= rst_hi_nxt;
            pf_n_r <= pf_n_nxt;
            bk_r <= bk_nxt;
        end
    end

    assign reset_out_n = rst_n_r;
    assign reset_out = rst_hi_r;
    assign power_fail_flag_n = pf_n_r;
    assign supply_from_backup = bk_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W-1:0] low_cnt_r, low_cnt_nxt;

    // length of the current reset pulse, in clocks
    always_comb
    begin
        if (reset_out_n)
            low_cnt_nxt = '0;
        else
            low_cnt_nxt = low_cnt_r + CNT_W'(1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            low_cnt_r <= '0;
        else
            low_cnt_r <= low_cnt_nxt;
    end

    sequence s_supply_low;
        main_supply_low;
    endsequence

    // release after a counted pulse; only a rise in the clock
    // right after rst is left out; the first release is checked
    sequence s_release;
        $rose(reset_out_n) && !$past(rst);
    endsequence

    // a cause seen while reset is released starts a new pulse
    sequence s_trigger;
        reset_out_n && (main_supply_low || wd_fire);
    endsequence

    // short window only: the full pulse is checked by counter
    sequence s_held_low;
        (!reset_out_n) [*8];
    endsequence

    chk_reset_inverse: assert property ( // [R11]
        @(posedge clk) disable iff (rst) reset_out == !reset_out_n)
        else $error("active-high reset not inverse");

    chk_supply_low_reset: assert property ( // [R3]
        @(posedge clk) disable iff (rst) s_supply_low |=> !reset_out_n)
        else $error("reset not asserted on supply low");

    chk_hold_length: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        // the counter still shows the finished pulse here
        s_release |-> low_cnt_r >= CNT_W'(HOLD_CYC))
        else $error("reset hold too short");

    chk_hold_bound: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        (!reset_out_n && !main_supply_low && !wd_fire
            && st_r == RST_HOLD) |-> hold_r < CNT_W'(HOLD_CYC))
        else $error("reset hold overrun");

    chk_wd_clear: assert property ( // [R8]
        @(posedge clk) disable iff (rst) !reset_out_n |=> wd_r == '0)
        else $error("watchdog not cleared in reset");

    chk_float_off: assert property ( // [R7]
        @(posedge clk) disable iff (rst) kick == KICK_FLOAT |=> wd_r == '0)
        else $error("watchdog counts while floating");

    chk_wd_fire: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        (wd_fire && st_r == RST_IDLE) |=> !reset_out_n)
        else $error("timeout gave no reset");

    chk_pf_flag: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        (power_fail_sense_low && !backup_mode) |=> !power_fail_flag_n)
        else $error("power-fail flag not low");

    chk_backup_pf: assert property ( // [R14]
        @(posedge clk) disable iff (rst)
        supply_from_backup |-> !power_fail_flag_n)
        else $error("flag not forced low in backup");

    chk_supply_sel: assert property ( // [R10]
        @(posedge clk) disable iff (rst)
        !main_supply_low |=> !supply_from_backup)
        else $error("backup selected with good supply");

    chk_hold_restart: assert property ( // [R12]
        @(posedge clk) disable iff (rst) s_supply_low |=> hold_r == '0)
        else $error("hold not restarted on supply low");

    chk_hold_pulse: assert property ( // [R1]
        @(posedge clk) disable iff (rst) s_trigger |=> s_held_low)
        else $error("reset pulse cut short");

    chk_no_early_release: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        (!reset_out_n && hold_r < CNT_W'(HOLD_CYC - 1)) |=> !reset_out_n)
        else $error("reset released early");

    // counters only move by one; a skip would cut the interval
    chk_hold_count: assert property ( // [R15]
        @(posedge clk) disable iff (rst)
        (!reset_out_n && !main_supply_low
            && hold_r < CNT_W'(HOLD_CYC - 1))
            |=> hold_r == $past(hold_r) + CNT_W'(1))
        else $error("hold counter skipped");

    chk_wd_restart: assert property ( // [R13]
        @(posedge clk) disable iff (rst) s_release |-> wd_r == '0)
        else $error("watchdog not restarted at release");

    chk_wd_count: assert property ( // [R15]
        @(posedge clk) disable iff (rst)
        (reset_out_n && kick != KICK_FLOAT && !kick_edge && !wd_fire
            && !main_supply_low) |=> wd_r == $past(wd_r) + CNT_W'(1))
        else $error("watchdog counter skipped");

    chk_kick_service: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        (reset_out_n && kick_edge) |=> wd_r == '0)
        else $error("kick did not clear watchdog");

    chk_no_early_fire: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        (reset_out_n && !main_supply_low
            && wd_r < CNT_W'(WD_CYC - 1)) |=> reset_out_n)
        else $error("watchdog fired early");

    chk_pf_release: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        (!power_fail_sense_low && !backup_mode) |=> power_fail_flag_n)
        else $error("power-fail flag not high");

    chk_backup_sel: assert property ( // [R10]
        @(posedge clk) disable iff (rst)
        (main_supply_low && !main_above_backup) |=> supply_from_backup)
        else $error("backup not selected");
endmodule : svr_supervisor

// file: tb/svr_host.sv
// host model: services or neglects the kick input
`timescale 1ns/1ps
module svr_host
(
    // from the block and the bench
    input wire logic clk,
    input wire logic reset_out_n,
    input wire logic [2:0] mode,
    // decoded kick levels
    output logic kick_is_high = 1'b0,
    output logic kick_is_low = 1'b0
);
    logic lvl = 1'b0;
    int cnt = 0;
    // mode 0 floats, 1 holds low, 2 toggles every ten cycles,
    // 3 holds high, 4 shows both levels (taken as floating)
    always @(negedge clk)
    begin
        cnt = (cnt == 9 || !reset_out_n) ? 0 : cnt + 1;
        if (mode == 3'd2 && cnt == 9)
            lvl = !lvl;
        kick_is_high <= (mode == 3'd2 && lvl) || mode == 3'd3
            || mode == 3'd4;
        kick_is_low <= mode == 3'd1 || (mode == 3'd2 && !lvl)
            || mode == 3'd4;
    end
endmodule : svr_host

// file: tb/supervisor_watchdog_reset_test.sv
// testbench: reset hold, supply low, watchdog and power-fail flag
`timescale 1ns/1ps
module supervisor_watchdog_reset_test;
    import svr_pkg::*;
    localparam int HOLD = 20;
    localparam int WD = 50;
    logic clk = 0, rst = 1, sup_low = 0, above = 1, pf_low = 0;
    logic [2:0] mode = 3'd0;
    logic k_hi, k_lo, rst_n, rst_hi, pf_n, backup;
    int bad_count = 0, checks_done = 0;
    int n;
    always #25 clk = ~clk;
    svr_supervisor #(.HOLD_CYC(HOLD), .WD_CYC(WD)) uut (.clk(clk),
        .rst(rst), .main_supply_low(sup_low), .main_above_backup(above),
        .power_fail_sense_low(pf_low), .kick_is_high(k_hi),
        .kick_is_low(k_lo), .reset_out_n(rst_n), .reset_out(rst_hi),
        .power_fail_flag_n(pf_n), .supply_from_backup(backup));
    svr_host host (.clk(clk), .reset_out_n(rst_n), .mode(mode),
        .kick_is_high(k_hi), .kick_is_low(k_lo));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task automatic check_range(input int v, lo, hi, input string m);
        checks_done++;
        if (v < lo || v > hi)
        begin
            bad_count++;
            $display("wrong value at %0t: %s %0d", $time, m, v);
        end
    endtask : check_range
    // cycles until reset output reaches lvl, bounded by lim
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (rst_n !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
            check(rst_hi, ~rst_n, "inverse output");
        end
    endtask : wait_rst
    task automatic t_supply;
        @(negedge clk);
        sup_low = 1;
        above = 0;
        repeat (3 * HOLD) @(negedge clk);
        check(rst_n, 1'b0, "supply low reset");
        check(backup, 1'b1, "backup select");
        check(pf_n, 1'b0, "flag in backup");
        sup_low = 0;
        above = 1;
        repeat (HOLD / 2) @(negedge clk);
        sup_low = 1;
        @(negedge clk);
        sup_low = 0;
        @(negedge clk);
        check(backup, 1'b0, "main select");
        wait_rst(1'b1, HOLD + 5);
        check_range(n, HOLD - 3, HOLD + 2, "restarted hold");
    endtask : t_supply
    task automatic t_watchdog;
        mode <= 3'd2;
        wait_rst(1'b0, 3 * WD);
        check_range(n, 3 * WD, 3 * WD, "serviced kick");
        mode <= 3'd4;
        wait_rst(1'b0, 3 * WD);
        check_range(n, 3 * WD, 3 * WD, "both levels");
        mode <= 3'd0;
        wait_rst(1'b0, 3 * WD);
        check_range(n, 3 * WD, 3 * WD, "floating kick");
        mode <= 3'd1;
        wait_rst(1'b0, 2 * WD);
        check_range(n, WD - 2, WD + 2, "steady kick");
        wait_rst(1'b1, HOLD + 5);
        check_range(n, HOLD - 2, HOLD + 2, "fired hold");
        wait_rst(1'b0, 2 * WD);
        check_range(n, WD - 2, WD + 2, "timer from zero");
        wait_rst(1'b1, HOLD + 5);
        mode <= 3'd3;
        wait_rst(1'b0, 2 * WD);
        check_range(n, WD, WD + 3, "steady high kick");
        mode <= 3'd0;
        wait_rst(1'b1, HOLD + 5);
        check_range(n, HOLD - 2, HOLD + 2, "hold then float");
    endtask : t_watchdog
    task automatic t_power_fail;
        for (int i = 0; i < 3; i++)
        begin
            pf_low = i[0];
            repeat (2) @(negedge clk);
            check(pf_n, ~pf_low, "power fail flag");
        end
    endtask : t_power_fail
    task automatic t_rerun;
        rst = 1;
        @(negedge clk);
        check(rst_n, 1'b0, "reset while rst");
        check(rst_hi, 1'b1, "inverse while rst");
        rst = 0;
        wait_rst(1'b1, HOLD + 5);
        check_range(n, HOLD - 2, HOLD + 2, "hold after rst");
    endtask : t_rerun
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 0;
        wait_rst(1'b1, HOLD + 5);
        check_range(n, HOLD - 2, HOLD + 2, "power-up hold");
        t_power_fail();
        t_supply();
        t_watchdog();
        t_rerun();
        test_done();
    end
    // well past the expected run of under two thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule : supervisor_watchdog_reset_test
